// file: rwc_pkg.sv
package rwc_pkg;
  // Crystal and tick rates; the prescaler divides one into the other.
  localparam int XTAL_HZ      = 32768;
  localparam int TICK_HZ      = 1;
  localparam int PRESCALE_DIV = XTAL_HZ / TICK_HZ;

  // Counter widths and last values before a wrap.
  localparam int SEC_W  = 6;
  localparam int MIN_W  = 6;
  localparam int HOUR_W = 5;
  localparam int DAY_W  = 15;
  localparam int SW_W   = 16;
  localparam logic [SEC_W-1:0]  SEC_LAST  = 6'h3B;
  localparam logic [MIN_W-1:0]  MIN_LAST  = 6'h3B;
  localparam logic [HOUR_W-1:0] HOUR_LAST = 5'h17;

  // Time-of-day word layout.
  localparam int SEC_LSB  = 0;
  localparam int MIN_LSB  = 8;
  localparam int HOUR_LSB = 16;

  // Register byte offsets.
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TIME    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DAY     = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_ALM_TOD = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_ALM_DAY = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_SW      = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STAT    = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_MASK    = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_WAKE    = 8'h20;

  // Control bits.
  localparam int CTL_W       = 4;
  localparam int CTL_HALT    = 0;
  localparam int CTL_ALM_TOD = 1;
  localparam int CTL_ALM_DAY = 2;
  localparam int CTL_SW_EN   = 3;

  // Event bits, shared by status, mask and wake enable.
  localparam int EV_W       = 7;
  localparam int EV_SEC     = 0;
  localparam int EV_MIN     = 1;
  localparam int EV_HOUR    = 2;
  localparam int EV_DAY     = 3;
  localparam int EV_ALM_TOD = 4;
  localparam int EV_ALM_DAY = 5;
  localparam int EV_SW      = 6;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: rwc_link_if.sv
`timescale 1ns/10ps
interface rwc_link_if;
  logic                     ce;
  logic                     sec_tick;
  logic                     sw_load;
  logic                     sw_en;
  logic [rwc_pkg::SW_W-1:0] sw_value;
  logic [rwc_pkg::SW_W-1:0] sw_count;
  logic                     sw_under;
  modport pre  (input ce, output sec_tick);
  modport sw   (input ce, sec_tick, sw_load, sw_en, sw_value,
                output sw_count, sw_under);
  modport core (output ce, sw_load, sw_en, sw_value,
                input sec_tick, sw_count, sw_under);
endinterface

// file: rwc_prescale.sv
`timescale 1ns/10ps
module rwc_prescale #(
  parameter int DIV = rwc_pkg::PRESCALE_DIV
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Crystal clock, sampled as a level
  input wire logic xtal_in,
  // Tick towards the core
  rwc_link_if.pre  lnk
);
  import rwc_pkg::*;
  localparam int CW = $clog2(DIV);
  typedef struct packed {
    logic          sync1;
    logic          sync2;
    logic          prev;
    logic [CW-1:0] cnt;
    logic          tick;
  } rwc_pre_type;
  rwc_pre_type q, n;

  always_comb begin
    n       = q;
    n.tick  = 1'b0;
    n.sync1 = xtal_in;
    n.sync2 = q.sync1;
    n.prev  = q.sync2;
    // The crystal keeps toggling in low-power states, so this stops only while ce is low.
    if (q.sync2 && !q.prev) begin
      if (q.cnt == CW'(DIV - 1)) begin
        n.cnt  = '0;
        n.tick = 1'b1;
      end else begin
        n.cnt = q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else if (lnk.ce) begin
      q <= n;
    end
  end

  assign lnk.sec_tick = q.tick;

  // A frozen tick is not a new wrap, so only look after an enabled edge.
  tick_on_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.tick && $past(lnk.ce))
    |-> (q.cnt == '0 && $past(q.cnt) == CW'(DIV - 1)))
    else $error("Second tick without a prescaler wrap.");
endmodule

// file: rwc_swatch.sv
`timescale 1ns/10ps
module rwc_swatch (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Load and count towards the core
  rwc_link_if.sw   lnk
);
  import rwc_pkg::*;
  typedef struct packed {
    logic [SW_W-1:0] cnt;
    logic            armed;
    logic            under;
  } rwc_sw_type;
  rwc_sw_type q, n;

  always_comb begin
    n       = q;
    n.under = 1'b0;
    if (lnk.sw_load) begin
      n.cnt   = lnk.sw_value;
      n.armed = 1'b1;
    end else if (lnk.sec_tick && lnk.sw_en) begin
      if (q.cnt != '0) begin
        n.cnt = q.cnt - 1'b1;
      end else if (q.armed) begin
        // Fires once per load so a stale zero does not interrupt forever.
        n.under = 1'b1;
        n.armed = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else if (lnk.ce) begin
      q <= n;
    end
  end

  assign lnk.sw_count = q.cnt;
  assign lnk.sw_under = q.under;

  sw_decrement_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (lnk.ce && lnk.sec_tick && lnk.sw_en && !lnk.sw_load && q.cnt != '0)
    |=> q.cnt == SW_W'($past(q.cnt) - 1'b1))
    else $error("Stopwatch did not count down by one.");

  sw_underflow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.under && $past(lnk.ce))
    |-> $past(lnk.sec_tick && lnk.sw_en && q.armed && q.cnt == '0))
    else $error("Stopwatch underflow without a tick at zero.");
endmodule

// file: rwc_top.sv
`timescale 1ns/10ps
// Behaviour
// - A prescaler divides the 32.768 kHz crystal clock down to a 1 Hz tick.
// - Seconds and minutes wrap after 60 and each wrap advances the next.
// - Hours wrap after 24 and advance a 32,768-day counter.
// - Each second, minute, hour and day rollover is a selectable event.
// - An enabled alarm raises an event when the time equals its setting.
// - The daily alarm compares hours, minutes and seconds only.
// - The day alarm compares the day count as well as the time of day.
// - The stopwatch loads a value and counts it down once per second.
// - An enabled stopwatch raises an event when it underflows below zero.
// - The stopwatch event is maskable like the periodic and alarm events.
// - Any enabled event raises a wakeup towards power management.
// - The wakeup serves sleep, deep sleep and hibernate exit alike.
// - Prescaler and counters keep running during chip low-power states.
module rwc_top #(
  parameter int PRESCALE = rwc_pkg::PRESCALE_DIV
) (
  // Clock, reset and clock enable
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       ce,
  // Crystal clock
  input  wire logic                       xtal_in,
  // AXI4-Lite write address
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [rwc_pkg::ADDR_W-1:0] awaddr,
  // AXI4-Lite write data
  input  wire logic                       wvalid,
  output logic                            wready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  // AXI4-Lite write response
  output logic                            bvalid,
  input  wire logic                       bready,
  output logic [1:0]                      bresp,
  // AXI4-Lite read address
  input  wire logic                       arvalid,
  output logic                            arready,
  input  wire logic [rwc_pkg::ADDR_W-1:0] araddr,
  // AXI4-Lite read data
  output logic                            rvalid,
  input  wire logic                       rready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  // Events towards interrupt controller and power management
  output logic                            irq,
  output logic                            wake
);
  import rwc_pkg::*;

  typedef struct packed {
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [1:0]          rresp;
    logic [31:0]         rdata;
    logic                aw_have;
    logic                w_have;
    logic                ar_have;
    logic [ADDR_W-1:0]   awaddr;
    logic [ADDR_W-1:0]   araddr;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic [CTL_W-1:0]    ctrl;
    logic [SEC_W-1:0]    sec;
    logic [MIN_W-1:0]    min;
    logic [HOUR_W-1:0]   hour;
    logic [DAY_W-1:0]    day;
    logic [SEC_W-1:0]    alm_sec;
    logic [MIN_W-1:0]    alm_min;
    logic [HOUR_W-1:0]   alm_hour;
    logic [DAY_W-1:0]    alm_day;
    logic [SW_W-1:0]     sw_value;
    logic                sw_load;
    logic [EV_W-1:0]     status;
    logic [EV_W-1:0]     mask;
    logic [EV_W-1:0]     wake_en;
    logic                irq;
    logic                wake;
  } rwc_core_type;

  rwc_core_type    q;
  rwc_core_type    n;
  logic            tick;
  logic            wr_go;
  logic            tod_hit;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] clr;
  logic [31:0]     wv;
  logic [31:0]     wz;

  rwc_link_if lnk ();

  rwc_prescale #(
    .DIV (PRESCALE)
  ) u_pre (
    .aclk    (aclk),
    .aresetn (aresetn),
    .xtal_in (xtal_in),
    .lnk     (lnk)
  );

  rwc_swatch u_sw (
    .aclk    (aclk),
    .aresetn (aresetn),
    .lnk     (lnk)
  );

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_CTRL, OFS_TIME, OFS_DAY, OFS_ALM_TOD, OFS_ALM_DAY,
      OFS_SW, OFS_STAT, OFS_MASK, OFS_WAKE: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] pack_tod(input logic [HOUR_W-1:0] h,
                                           input logic [MIN_W-1:0]  m,
                                           input logic [SEC_W-1:0]  s);
    logic [31:0] w;
    w                     = '0;
    w[SEC_LSB +: SEC_W]   = s;
    w[MIN_LSB +: MIN_W]   = m;
    w[HOUR_LSB +: HOUR_W] = h;
    return w;
  endfunction

  // Byte lanes without a strobe keep the old value.
  function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  strb);
    logic [31:0] w;
    w = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        w[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return w;
  endfunction

  function automatic logic [31:0] read_word(input rwc_core_type s,
                                            input logic [ADDR_W-1:0] a,
                                            input logic [SW_W-1:0] swc);
    logic [31:0] w;
    w = '0;
    case (a)
      OFS_CTRL:    w[CTL_W-1:0] = s.ctrl;
      OFS_TIME:    w = pack_tod(s.hour, s.min, s.sec);
      OFS_DAY:     w[DAY_W-1:0] = s.day;
      OFS_ALM_TOD: w = pack_tod(s.alm_hour, s.alm_min, s.alm_sec);
      OFS_ALM_DAY: w[DAY_W-1:0] = s.alm_day;
      OFS_SW:      w[SW_W-1:0] = swc;
      OFS_STAT:    w[EV_W-1:0] = s.status;
      OFS_MASK:    w[EV_W-1:0] = s.mask;
      OFS_WAKE:    w[EV_W-1:0] = s.wake_en;
      default:     w = '0;
    endcase
    return w;
  endfunction

  always_comb begin
    n         = q;
    n.sw_load = 1'b0;
    ev        = '0;
    clr       = '0;
    wv        = '0;
    wz        = '0;
    tod_hit   = 1'b0;
    wr_go     = q.aw_have && q.w_have && !q.bvalid;
    tick      = lnk.sec_tick && !q.ctrl[CTL_HALT];

    // Timekeeping; the halt bit lets software set the time without races.
    if (tick) begin
      ev[EV_SEC] = 1'b1;
      if (q.sec == SEC_LAST) begin
        n.sec      = '0;
        ev[EV_MIN] = 1'b1;
        if (q.min == MIN_LAST) begin
          n.min       = '0;
          ev[EV_HOUR] = 1'b1;
          if (q.hour == HOUR_LAST) begin
            n.hour     = '0;
            n.day      = q.day + 1'b1;
            ev[EV_DAY] = 1'b1;
          end else begin
            n.hour = q.hour + 1'b1;
          end
        end else begin
          n.min = q.min + 1'b1;
        end
      end else begin
        n.sec = q.sec + 1'b1;
      end
      tod_hit = n.sec == q.alm_sec && n.min == q.alm_min &&
                n.hour == q.alm_hour;
    end
    ev[EV_ALM_TOD] = tod_hit && q.ctrl[CTL_ALM_TOD];
    ev[EV_ALM_DAY] = tod_hit && n.day == q.alm_day &&
                     q.ctrl[CTL_ALM_DAY];
    ev[EV_SW]      = lnk.sw_under;

    // Write address and data may arrive in either order.
    if (awvalid && q.awready) begin
      n.aw_have = 1'b1;
      n.awaddr  = awaddr;
    end
    if (wvalid && q.wready) begin
      n.w_have = 1'b1;
      n.wdata  = wdata;
      n.wstrb  = wstrb;
    end
    if (bready && q.bvalid) begin
      n.bvalid = 1'b0;
    end
    if (wr_go) begin
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = is_mapped(q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      wv = apply_strb(read_word(q, q.awaddr, lnk.sw_count),
                      q.wdata, q.wstrb);
      wz = apply_strb(32'h0, q.wdata, q.wstrb);
      // A write to the time registers wins over a tick in the same cycle.
      case (q.awaddr)
        OFS_CTRL: n.ctrl = wv[CTL_W-1:0];
        OFS_TIME: begin
          n.sec  = wv[SEC_LSB +: SEC_W];
          n.min  = wv[MIN_LSB +: MIN_W];
          n.hour = wv[HOUR_LSB +: HOUR_W];
        end
        OFS_DAY: n.day = wv[DAY_W-1:0];
        OFS_ALM_TOD: begin
          n.alm_sec  = wv[SEC_LSB +: SEC_W];
          n.alm_min  = wv[MIN_LSB +: MIN_W];
          n.alm_hour = wv[HOUR_LSB +: HOUR_W];
        end
        OFS_ALM_DAY: n.alm_day = wv[DAY_W-1:0];
        OFS_SW: begin
          n.sw_value = wv[SW_W-1:0];
          n.sw_load  = 1'b1;
        end
        OFS_STAT: clr = wz[EV_W-1:0];
        OFS_MASK: n.mask = wv[EV_W-1:0];
        OFS_WAKE: n.wake_en = wv[EV_W-1:0];
        default: ;
      endcase
    end
    n.awready = !n.aw_have;
    n.wready  = !n.w_have;

    // Read channel: one outstanding read, answered one cycle later.
    if (rready && q.rvalid) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && q.arready) begin
      n.ar_have = 1'b1;
      n.araddr  = araddr;
    end
    if (q.ar_have && !q.rvalid) begin
      n.ar_have = 1'b0;
      n.rvalid  = 1'b1;
      n.rdata   = read_word(q, q.araddr, lnk.sw_count);
      n.rresp   = is_mapped(q.araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    n.arready = !n.ar_have && !n.rvalid;

    // A new event beats a clear written in the same cycle.
    n.status = (q.status & ~clr) | ev;
    n.irq    = |(n.status & n.mask);
    // Wakeup is a level so that any power state can sample it.
    n.wake   = |(n.status & n.wake_en);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else if (ce) begin
      q <= n;
    end
  end

  assign lnk.ce       = ce;
  assign lnk.sw_load  = q.sw_load;
  assign lnk.sw_value = q.sw_value;
  assign lnk.sw_en    = q.ctrl[CTL_SW_EN];

  assign awready = q.awready;
  assign wready  = q.wready;
  assign bvalid  = q.bvalid;
  assign bresp   = q.bresp;
  assign arready = q.arready;
  assign rvalid  = q.rvalid;
  assign rdata   = q.rdata;
  assign rresp   = q.rresp;
  assign irq     = q.irq;
  assign wake    = q.wake;

  sec_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && tick && !wr_go && q.sec == SEC_LAST)
    |=> (q.sec == '0 && q.status[EV_MIN]))
    else $error("Seconds did not wrap into a minute.");

  day_advance_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && tick && !wr_go && q.sec == SEC_LAST && q.min == MIN_LAST &&
     q.hour == HOUR_LAST)
    |=> (q.hour == '0 && q.day == DAY_W'($past(q.day) + 1'b1)))
    else $error("Hour wrap did not advance the day.");

  sec_event_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && tick) |=> q.status[EV_SEC])
    else $error("Second tick did not set its event.");

  alarm_tod_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ($rose(q.status[EV_ALM_TOD]) && $past(!wr_go))
    |-> (q.sec == q.alm_sec && q.min == q.alm_min &&
         q.hour == q.alm_hour && q.ctrl[CTL_ALM_TOD]))
    else $error("Daily alarm fired away from its time.");

  alarm_day_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ($rose(q.status[EV_ALM_DAY]) && $past(!wr_go))
    |-> (q.day == q.alm_day && q.hour == q.alm_hour &&
         q.min == q.alm_min && q.sec == q.alm_sec &&
         q.ctrl[CTL_ALM_DAY]))
    else $error("Day alarm fired away from its day and time.");

  status_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && q.status[EV_SEC] && !wr_go) |=> q.status[EV_SEC])
    else $error("Pending event lost without a clear.");

  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    q.irq == |(q.status & q.mask))
    else $error("Interrupt does not follow enabled pending events.");

  wake_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    q.wake == |(q.status & q.wake_en))
    else $error("Wakeup does not follow enabled pending events.");
endmodule

// file: rwc_pm_model.sv
`timescale 1ns/10ps
// Stands in for interrupt control and power management. Once asleep it
// wakes only on the wake level, so a wake that never rises stays visible.
module rwc_pm_model (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Events from the clock block
  input  wire logic irq,
  input  wire logic wake,
  // Sleep request and observed state
  input  wire logic sleep_req,
  output logic      asleep_q,
  output int        irq_rises_q
);
  logic irq_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      asleep_q    <= 1'b0;
      irq_q       <= 1'b0;
      irq_rises_q <= 0;
    end else begin
      irq_q <= irq;
      if (irq && !irq_q) begin
        irq_rises_q <= irq_rises_q + 1;
      end
      if (wake) begin
        asleep_q <= 1'b0;
      end else if (sleep_req) begin
        asleep_q <= 1'b1;
      end
    end
  end
endmodule

// file: rwc_top_tb.sv
`timescale 1ns/10ps
module rwc_top_tb;
  import rwc_pkg::*;
  logic              aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic              xtal_in = 1'b0, xtal_run = 1'b0, sleep_req = 1'b0;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic              arvalid = 1'b0, rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic              irq, wake, asleep;
  logic [ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]       wdata = 32'h0, rdata, st, v, rt;
  logic [3:0]        wstrb = 4'h0;
  logic [1:0]        bresp, rresp, xcnt = 2'h0;
  int                failures, check_count, cyc, irq_rises, n0;
  logic [7:0]        regs [9] = '{OFS_CTRL, OFS_TIME, OFS_DAY,
                                  OFS_ALM_TOD, OFS_ALM_DAY, OFS_SW,
                                  OFS_STAT, OFS_MASK, OFS_WAKE};
  logic [31:0]       ct [3] = '{32'h00173B3B, 32'h00003B3B, 32'h000C2238};
  logic [14:0]       cd [3] = '{15'h7FFF, 15'h3, 15'h0};

  always #5 aclk = ~aclk;

  // The crystal stays still until the reset values have been read, so
  // no tick can disturb them; then it toggles every fourth cycle.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    xcnt <= xcnt + 2'h1;
    if (xtal_run && xcnt == 2'h3) begin
      xtal_in <= ~xtal_in;
    end
  end

  rwc_top #(.PRESCALE(4)) i_rwc_top (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .xtal_in(xtal_in),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .irq(irq), .wake(wake)
  );

  rwc_pm_model i_rwc_pm_model (
    .aclk(aclk), .aresetn(aresetn), .irq(irq), .wake(wake),
    .sleep_req(sleep_req), .asleep_q(asleep), .irq_rises_q(irq_rises)
  );

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    chk(32'(rresp), 32'(er));
  endtask

  function automatic logic [3:0] roll(input logic [31:0] t);
    logic s, m, h;
    s = t[5:0] == SEC_LAST;
    m = s && t[13:8] == MIN_LAST;
    h = m && t[20:16] == HOUR_LAST;
    return {h, m, s, 1'b1};
  endfunction

  function automatic logic [31:0] nxt(input logic [31:0] t);
    logic [3:0] r;
    logic [5:0] s, m;
    logic [4:0] h;
    r = roll(t);
    s = r[1] ? 6'h0 : t[5:0] + 6'h1;
    m = r[2] ? 6'h0 : t[13:8] + 6'(r[1]);
    h = r[3] ? 5'h0 : t[20:16] + 5'(r[2]);
    return {11'h0, h, 2'h0, m, 2'h0, s};
  endfunction

  // Clearing first means a status read with the seconds bit (bit 0) set marks a
  // tick that happened after this call, which gives a known phase.
  task automatic sync_tick(output logic [31:0] s);
    wr(OFS_STAT, 32'h7F);
    do rd(OFS_STAT, s); while (s[EV_SEC] !== 1'b1);
  endtask

  task automatic tick_check(input logic [31:0] t, input logic [14:0] d);
    logic [31:0] s, g;
    logic [14:0] e;
    int c;
    e = d + 15'(roll(t) >> 3);
    sync_tick(s);
    c = cyc;
    wr(OFS_TIME, t);
    wr(OFS_DAY, 32'(d));
    sync_tick(s);
    chk(32'((cyc - c) inside {[26:38]}), 32'h1);
    chk(32'(s[3:0]), 32'(roll(t)));
    rd(OFS_TIME, g);
    chk(g, nxt(t));
    rd(OFS_DAY, g);
    chk(g, 32'(e));
  endtask

  task automatic alarm(input logic [31:0] ctrl, input logic [14:0] ad,
                       input logic [1:0] e);
    logic [31:0] s;
    wr(OFS_ALM_DAY, 32'(ad));
    wr(OFS_CTRL, ctrl);
    wr(OFS_ALM_TOD, 32'h00080F1F);
    sync_tick(s);
    wr(OFS_TIME, 32'h00080F1E);
    wr(OFS_DAY, 32'h64);
    sync_tick(s);
    chk(32'(s[EV_ALM_DAY:EV_ALM_TOD]), 32'(e));
  endtask

  task automatic results;
    $display("Checks %0d, failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    results();
  end

  initial begin
    v = $urandom(32'hED1D);
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (regs[i]) begin
      rd(regs[i], v);
      chk(v, 32'h0);
    end
    rd(8'h40, v, RESP_SLVERR);
    chk(v, 32'h0);
    wr(8'h40, 32'hFFFFFFFF, RESP_SLVERR);
    chk(32'({irq, wake}), 32'h0);
    xtal_run <= 1'b1;
    foreach (ct[i]) begin
      tick_check(ct[i], cd[i]);
    end
    repeat (5) begin
      rt = {11'h0, 5'($urandom_range(23)), 2'h0, 6'($urandom_range(59)),
            2'h0, 6'($urandom_range(59))};
      tick_check(rt, 15'($urandom_range(32767)));
    end
    alarm(32'h0, 15'h64, 2'h0);
    alarm(32'h2, 15'h64, 2'h1);
    alarm(32'h4, 15'h65, 2'h0);
    alarm(32'h6, 15'h64, 2'h3);
    // Both alarm flags now stay pending; mask and wake enable act on the day alarm flag only.
    sleep_req <= 1'b1;
    repeat (2) @(posedge aclk);
    sleep_req <= 1'b0;
    chk(32'(asleep), 32'h1);
    // The span covers more than one tick period, so time must move on.
    rd(OFS_TIME, v);
    repeat (40) @(posedge aclk);
    rd(OFS_TIME, rt);
    chk(32'(rt !== v), 32'h1);
    chk(32'(asleep), 32'h1);
    wr(OFS_WAKE, 32'h20);
    repeat (2) @(posedge aclk);
    chk(32'(wake), 32'h1);
    chk(32'(asleep), 32'h0);
    chk(32'(irq), 32'h0);
    n0 = irq_rises;
    wr(OFS_MASK, 32'h20);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h1);
    chk(32'(irq_rises), 32'(n0 + 1));
    rd(OFS_STAT, v);
    chk(32'(v[EV_ALM_DAY]), 32'h1);
    wr(OFS_STAT, 32'h20);
    repeat (2) @(posedge aclk);
    chk(32'({irq, wake}), 32'h0);
    wr(OFS_MASK, 32'h0);
    wr(OFS_WAKE, 32'h0);
    wr(OFS_CTRL, 32'h8);
    sync_tick(st);
    wr(OFS_SW, 32'h2);
    rd(OFS_SW, v);
    chk(v, 32'h2);
    for (int k = 1; k <= 3; k++) begin
      sync_tick(st);
      rd(OFS_SW, v);
      chk(v, 32'(k > 1 ? 0 : 2 - k));
      rd(OFS_STAT, v);
      chk(32'(v[EV_SW]), 32'(k == 3));
    end
    wr(OFS_MASK, 32'h40);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h1);
    results();
  end
endmodule
